// ==== rtl/pcx_crossbar.sv ====
`timescale 1ns/10ps
// What this block does
// - Disabled peripherals never reach any pin.
// - First serial port always on pins 0.0/0.1.
// - Serial peripherals request all their pins together.
// - Free pins are GPIO, byte and bit access.
// - Allocated pins ignore port data writes.
// - Normal port read returns pin level.
// - Read-modify-write read returns output latch.
// - Drivers off until global enable bit set.
// - Peripheral input pins have drivers forced off.
// - Push-pull drives both levels from data.
// - Open-drain drives low, releases on one.
// - One mode bit per pin, 1 push-pull.
// - Mode bits reset to open-drain.
// - Two-wire pins, mode-0 receive pins forced open-drain.
// - Pull-ups on, global off, off when low.
// - Analog pin reads zero, no pull-up, skipped.
module pcx_crossbar (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address and data.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral side, one slot per signal.
  input wire logic [32:0] sig_out,
  input wire logic [32:0] sig_oe,
  output logic [32:0] sig_in,
  // Peripheral modes that change pin use.
  input wire logic serial0_mode0,
  input wire logic serial1_mode0,
  input wire logic spi_three_wire,
  // Package pins.
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [31:0] pin_pullup
);
  // Configuration and port registers.
  logic [7:0] xbar_cfg_0;
  logic [7:0] xbar_cfg_1;
  logic [7:0] xbar_cfg_2;
  logic [7:0] xbar_cfg_3;
  logic [31:0] port_latch; // Port data latches, port 0 in bits 7:0.
  logic [31:0] port_out_mode_reg;
  logic [31:0] port_in_mode_reg; // A 0 makes the pin analog.
  // Bus channel state.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // Derived configuration.
  logic xbar_global_enable;
  logic pullup_global_disable;
  logic [2:0] cex_count;
  logic [32:0] sig_en;
  logic [31:0] analog_pin;
  // Allocator results.
  logic [31:0] pin_taken;
  logic [5:0] pin_sig [32];
  logic [32:0] sig_placed;
  logic [4:0] sig_pin [33];
  // Pin side.
  logic [31:0] pin_level;
  logic [31:0] pin_read;
  logic [32:0] sig_is_input;
  logic [32:0] sig_force_od;
  logic [31:0] drv_data;
  logic [31:0] drv_want;
  logic [31:0] drv_od;
  logic [31:0] drv_oe;
  // Bus decode.
  logic do_write;
  logic ar_take;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] next_latch;

  // Byte strobes widened to a bit mask, so each port byte is separately writable.
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  // True for every byte address the block answers.
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr[1:0] == 2'h0) && (addr <= pcx_pkg::ADDR_ALLOC);
  endfunction : addr_mapped

  // Unpack the configuration fields.
  assign xbar_global_enable = xbar_cfg_2[pcx_pkg::C2_XBEN];
  assign pullup_global_disable = xbar_cfg_2[pcx_pkg::C2_PUD];
  assign cex_count = xbar_cfg_0[pcx_pkg::C0_CEX_LO +: 3];

  // Turn enable bits into per-signal requests. A serial peripheral enables
  // all of its slots from one bit, so its slots are requested together; the SPI select slot also needs spi_three_wire low.
  always_comb begin
    sig_en = 33'h0_0000_0000;
    sig_en[pcx_pkg::S_TXA] = xbar_cfg_0[pcx_pkg::C0_SER0];
    sig_en[pcx_pkg::S_RXA] = xbar_cfg_0[pcx_pkg::C0_SER0];
    for (int k = 0; k < 4; k++) begin
      sig_en[pcx_pkg::S_SPI + k] = xbar_cfg_0[pcx_pkg::C0_SPI];
    end
    // In three-wire mode the select line stays off the pins.
    sig_en[pcx_pkg::S_NSS] = xbar_cfg_0[pcx_pkg::C0_SPI] & ~spi_three_wire;
    sig_en[pcx_pkg::S_SDA] = xbar_cfg_0[pcx_pkg::C0_SMB];
    sig_en[pcx_pkg::S_SCL] = xbar_cfg_0[pcx_pkg::C0_SMB];
    sig_en[pcx_pkg::S_TXB] = xbar_cfg_2[pcx_pkg::C2_SER1];
    sig_en[pcx_pkg::S_RXB] = xbar_cfg_2[pcx_pkg::C2_SER1];
    // Capture/compare outputs are enabled by count, lowest first.
    for (int k = 0; k < 6; k++) begin
      sig_en[pcx_pkg::S_CEX + k] = (cex_count > 3'(k));
    end
    sig_en[pcx_pkg::S_ECI] = xbar_cfg_0[pcx_pkg::C0_ECI];
    sig_en[pcx_pkg::S_CP0] = xbar_cfg_0[pcx_pkg::C0_CP0];
    sig_en[pcx_pkg::S_CP0 + 1] = xbar_cfg_1[pcx_pkg::C1_CP1];
    sig_en[pcx_pkg::S_CP0 + 2] = xbar_cfg_3[pcx_pkg::C3_CP2];
    sig_en[pcx_pkg::S_T0] = xbar_cfg_1[pcx_pkg::C1_T0];
    sig_en[pcx_pkg::S_T0 + 1] = xbar_cfg_1[pcx_pkg::C1_INT0];
    sig_en[pcx_pkg::S_T0 + 2] = xbar_cfg_1[pcx_pkg::C1_T1];
    sig_en[pcx_pkg::S_T0 + 3] = xbar_cfg_1[pcx_pkg::C1_INT1];
    sig_en[pcx_pkg::S_T0 + 4] = xbar_cfg_1[pcx_pkg::C1_T2];
    sig_en[pcx_pkg::S_T0 + 5] = xbar_cfg_1[pcx_pkg::C1_T2EX];
    sig_en[pcx_pkg::S_T0 + 6] = xbar_cfg_3[pcx_pkg::C3_T3];
    sig_en[pcx_pkg::S_T0 + 7] = xbar_cfg_3[pcx_pkg::C3_T3EX];
    sig_en[pcx_pkg::S_T0 + 8] = xbar_cfg_2[pcx_pkg::C2_T4];
    sig_en[pcx_pkg::S_T0 + 9] = xbar_cfg_2[pcx_pkg::C2_T4EX];
    sig_en[pcx_pkg::S_SYSCLK] = xbar_cfg_1[pcx_pkg::C1_SYSCLK];
    sig_en[pcx_pkg::S_CNV0] = xbar_cfg_2[pcx_pkg::C2_CNV0];
    sig_en[pcx_pkg::S_CNV2] = xbar_cfg_3[pcx_pkg::C3_CNV2];
  end

  // Analog pins are passed over by the allocator.
  assign analog_pin = ~(port_in_mode_reg | pcx_pkg::IMODE_FIXED);

  // Priority allocation. The first serial port is slot 0 and port 0 is never
  // analog, so its pins always land on 0.0 and 0.1.
  pcx_alloc u_alloc (
    .sig_en(sig_en),
    .pin_skip(analog_pin),
    .pin_taken(pin_taken),
    .pin_sig(pin_sig),
    .sig_placed(sig_placed),
    .sig_pin(sig_pin)
  );

  // Pin inputs come from outside the clock domain.
  pcx_sync u_sync (
    .clk(clk),
    .reset(reset),
    .raw(pin_in),
    .level(pin_level)
  );

  // A serial receive line in mode 0 becomes bidirectional and open-drain.
  always_comb begin
    sig_is_input = pcx_pkg::SIG_INPUT_MASK;
    sig_is_input[pcx_pkg::S_RXA] = ~serial0_mode0;
    sig_is_input[pcx_pkg::S_RXB] = ~serial1_mode0;
    sig_force_od = 33'h0_0000_0000;
    sig_force_od[pcx_pkg::S_SDA] = 1'b1;
    sig_force_od[pcx_pkg::S_SCL] = 1'b1;
    sig_force_od[pcx_pkg::S_RXA] = serial0_mode0;
    sig_force_od[pcx_pkg::S_RXB] = serial1_mode0;
  end

  // Per-pin driver. Allocated pins take value and enable from their peripheral;
  // free pins take the latch. Nothing drives before the global enable.
  generate
    for (genvar p = 0; p < pcx_pkg::NUM_PIN; p++) begin : g_pin
      wire [5:0] sel = pin_sig[p];
      wire taken = pin_taken[p];
      assign drv_data[p] = taken ? sig_out[sel] : port_latch[p];
      assign drv_want[p] = taken ? (~sig_is_input[sel] & sig_oe[sel]) : 1'b1;
      assign drv_od[p] = ~port_out_mode_reg[p] | (taken & sig_force_od[sel]);
      // Open-drain only ever drives a 0; push-pull drives both levels.
      assign drv_oe[p] = xbar_global_enable & drv_want[p]
        & (~drv_data[p] | ~drv_od[p]);
      assign pin_out[p] = drv_data[p];
      assign pin_oe[p] = drv_oe[p];
      // The pull-up yields to a pin driving low and to analog pins.
      assign pin_pullup[p] = ~pullup_global_disable & ~analog_pin[p]
        & ~(drv_oe[p] & ~drv_data[p]);
    end
  endgenerate

  // Peripheral inputs see only their own pin, and only while enabled.
  generate
    for (genvar s = 0; s < pcx_pkg::NUM_SIG; s++) begin : g_sig
      assign sig_in[s] = sig_placed[s] ? pin_level[sig_pin[s]] : pcx_pkg::SIG_IDLE;
    end
  endgenerate

  // Pin reads return the real level; analog pins read 0.
  assign pin_read = pin_level & ~analog_pin;

  // Write channel: address and data are taken in either order and held
  // until the write is done; nothing new is taken while a response waits.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit = addr_mapped(aw_addr);
  assign wmask = strb_mask(w_strb);

  // Hold address and data of the write under way.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response one edge after both halves are held.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcx_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? pcx_pkg::RESP_OKAY : pcx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Latch update: bytewise through the data register, bitwise through the
  // set and clear registers. Allocated pins keep the stored bit but their
  // pin does not follow it.
  always_comb begin
    next_latch = port_latch;
    if (do_write) begin
      case (aw_addr)
        pcx_pkg::ADDR_DATA: next_latch = (port_latch & ~wmask) | (w_data & wmask);
        pcx_pkg::ADDR_SET: next_latch = port_latch | (w_data & wmask);
        pcx_pkg::ADDR_CLR: next_latch = port_latch & ~(w_data & wmask);
        default: next_latch = port_latch;
      endcase
    end
  end

  // Register file. Mode bits reset to open-drain.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xbar_cfg_0 <= pcx_pkg::CFG_RESET;
      xbar_cfg_1 <= pcx_pkg::CFG_RESET;
      xbar_cfg_2 <= pcx_pkg::CFG_RESET;
      xbar_cfg_3 <= pcx_pkg::CFG_RESET;
      port_latch <= pcx_pkg::DATA_RESET;
      port_out_mode_reg <= pcx_pkg::OMODE_RESET;
      port_in_mode_reg <= pcx_pkg::IMODE_RESET;
    end else begin
      port_latch <= next_latch;
      if (do_write && w_strb[0]) begin
        case (aw_addr)
          pcx_pkg::ADDR_CFG0: xbar_cfg_0 <= w_data[7:0];
          pcx_pkg::ADDR_CFG1: xbar_cfg_1 <= w_data[7:0];
          pcx_pkg::ADDR_CFG2: xbar_cfg_2 <= w_data[7:0];
          pcx_pkg::ADDR_CFG3: xbar_cfg_3 <= w_data[7:0];
          default: xbar_cfg_0 <= xbar_cfg_0;
        endcase
      end
      if (do_write && aw_addr == pcx_pkg::ADDR_OMODE) begin
        port_out_mode_reg <= (port_out_mode_reg & ~wmask) | (w_data & wmask);
      end
      if (do_write && aw_addr == pcx_pkg::ADDR_IMODE) begin
        port_in_mode_reg <= (port_in_mode_reg & ~wmask) | (w_data & wmask);
      end
    end
  end

  // Read decode. The latch view is what a read-modify-write reads.
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_hit = addr_mapped(s_axi_araddr);
  always_comb begin
    case (s_axi_araddr)
      pcx_pkg::ADDR_CFG0: rd_word = {24'h00_0000, xbar_cfg_0};
      pcx_pkg::ADDR_CFG1: rd_word = {24'h00_0000, xbar_cfg_1};
      pcx_pkg::ADDR_CFG2: rd_word = {24'h00_0000, xbar_cfg_2};
      pcx_pkg::ADDR_CFG3: rd_word = {24'h00_0000, xbar_cfg_3};
      pcx_pkg::ADDR_DATA: rd_word = pin_read;
      pcx_pkg::ADDR_SET: rd_word = pin_read;
      pcx_pkg::ADDR_CLR: rd_word = pin_read;
      pcx_pkg::ADDR_LATCH: rd_word = port_latch;
      pcx_pkg::ADDR_OMODE: rd_word = port_out_mode_reg;
      pcx_pkg::ADDR_IMODE: rd_word = port_in_mode_reg | pcx_pkg::IMODE_FIXED;
      pcx_pkg::ADDR_ALLOC: rd_word = pin_taken;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // One read at a time; the address is refused while data waits.
  assign s_axi_arready = ~s_axi_rvalid;

  // Read data registered at the address handshake.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pcx_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? pcx_pkg::RESP_OKAY : pcx_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pcx_crossbar

// ==== rtl/pcx_pkg.sv ====
package pcx_pkg;
  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CFG2 = 8'h08;
  localparam logic [7:0] ADDR_CFG3 = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_SET = 8'h14;
  localparam logic [7:0] ADDR_CLR = 8'h18;
  localparam logic [7:0] ADDR_LATCH = 8'h1c;
  localparam logic [7:0] ADDR_OMODE = 8'h20;
  localparam logic [7:0] ADDR_IMODE = 8'h24;
  localparam logic [7:0] ADDR_ALLOC = 8'h28;
  // Reset values.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [31:0] DATA_RESET = 32'hffff_ffff;
  localparam logic [31:0] OMODE_RESET = 32'h0000_0000;
  localparam logic [31:0] IMODE_RESET = 32'hffff_ffff;
  // Port 0 has no analog function, so its input mode bits always read 1.
  localparam logic [31:0] IMODE_FIXED = 32'h0000_00ff;
  // Field positions, configuration register 0.
  localparam int C0_SMB = 0;
  localparam int C0_SPI = 1;
  localparam int C0_SER0 = 2;
  localparam int C0_CEX_LO = 3;
  localparam int C0_ECI = 6;
  localparam int C0_CP0 = 7;
  // Field positions, configuration register 1.
  localparam int C1_CP1 = 0;
  localparam int C1_T0 = 1;
  localparam int C1_INT0 = 2;
  localparam int C1_T1 = 3;
  localparam int C1_INT1 = 4;
  localparam int C1_T2 = 5;
  localparam int C1_T2EX = 6;
  localparam int C1_SYSCLK = 7;
  // Field positions, configuration register 2.
  localparam int C2_CNV0 = 0;
  localparam int C2_SER1 = 2;
  localparam int C2_T4 = 3;
  localparam int C2_XBEN = 4;
  localparam int C2_T4EX = 6;
  localparam int C2_PUD = 7;
  // Field positions, configuration register 3.
  localparam int C3_T3 = 0;
  localparam int C3_T3EX = 1;
  localparam int C3_CNV2 = 2;
  localparam int C3_CP2 = 3;
  // Peripheral signal slots in falling allocation priority.
  localparam int NUM_SIG = 33;
  localparam int NUM_PIN = 32;
  localparam int S_TXA = 0;
  localparam int S_RXA = 1;
  localparam int S_SPI = 2;
  localparam int S_NSS = 5;
  localparam int S_SDA = 6;
  localparam int S_SCL = 7;
  localparam int S_TXB = 8;
  localparam int S_RXB = 9;
  localparam int S_CEX = 10;
  localparam int S_ECI = 16;
  localparam int S_CP0 = 17;
  localparam int S_T0 = 20;
  localparam int S_SYSCLK = 30;
  localparam int S_CNV0 = 31;
  localparam int S_CNV2 = 32;
  // Slots that are peripheral inputs only; their drivers are held off.
  localparam logic [32:0] SIG_INPUT_MASK = 33'h1_bff1_0202;
  // Value a peripheral input sees when its signal has no pin.
  localparam logic SIG_IDLE = 1'b1;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pcx_pkg

// ==== rtl/pcx_sync.sv ====
`timescale 1ns/10ps
// Three-stage pin synchroniser; a change is accepted once the last two
// stages agree, which also rejects a single-cycle glitch.
module pcx_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Raw pin levels and the filtered result.
  input wire logic [31:0] raw,
  output logic [31:0] level
);
  logic [31:0] stage1; // Read by stage2 only.
  logic [31:0] stage2;
  logic [31:0] stage3;
  logic [31:0] next_level;

  // Take the new value only where stages two and three agree.
  assign next_level = (stage2 & stage3) | (level & (stage2 ^ stage3));

  // Shift chain and filtered level; pins idle high through the pull-ups.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= 32'hffff_ffff;
      stage2 <= 32'hffff_ffff;
      stage3 <= 32'hffff_ffff;
      level <= 32'hffff_ffff;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end
endmodule : pcx_sync

// ==== rtl/pcx_alloc.sv ====
`timescale 1ns/10ps
// Priority pin allocator: each enabled signal, in slot order, takes the
// lowest free pin that is not skipped.
module pcx_alloc (
  // Requests.
  input wire logic [32:0] sig_en,
  input wire logic [31:0] pin_skip,
  // Pin side of the result.
  output logic [31:0] pin_taken,
  output logic [5:0] pin_sig [32],
  // Signal side of the result.
  output logic [32:0] sig_placed,
  output logic [4:0] sig_pin [33]
);
  logic [31:0] free; // Pins still available while the walk runs.
  logic found; // Current signal already placed.

  // Purely combinational, so any configuration change re-routes at once.
  always_comb begin
    free = ~pin_skip;
    found = 1'b0;
    pin_taken = 32'h0000_0000;
    sig_placed = 33'h0_0000_0000;
    for (int p = 0; p < 32; p++) begin
      pin_sig[p] = 6'h00;
    end
    for (int s = 0; s < 33; s++) begin
      sig_pin[s] = 5'h00;
    end
    for (int s = 0; s < 33; s++) begin
      found = 1'b0;
      for (int p = 0; p < 32; p++) begin
        if (sig_en[s] && free[p] && !found) begin
          found = 1'b1;
          free[p] = 1'b0;
          pin_taken[p] = 1'b1;
          pin_sig[p] = 6'(s);
          sig_pin[s] = 5'(p);
          sig_placed[s] = 1'b1;
        end
      end
    end
  end
endmodule : pcx_alloc

// ==== tb/pcx_checker.sv ====
`timescale 1ns/10ps
// Port watcher; crossbar config bits are snooped from bus writes.
module pcx_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Bus side.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Peripheral and pin side.
  input wire logic [32:0] sig_out,
  input wire logic [32:0] sig_oe,
  input wire logic [32:0] sig_in,
  input wire logic serial0_mode0,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  // Captured write address, strobes and data.
  logic [7:0] aw_q;
  logic [3:0] st_q;
  logic [31:0] wd_q;
  logic [7:0] c0, c2;
  // The register changes as bvalid rises, so bypass the copy.
  wire logic hit0 = s_axi_bvalid && st_q[0] && aw_q == pcx_pkg::ADDR_CFG0;
  wire logic hit2 = s_axi_bvalid && st_q[0] && aw_q == pcx_pkg::ADDR_CFG2;
  wire logic [7:0] c0v = hit0 ? wd_q[7:0] : c0;
  wire logic [7:0] c2v = hit2 ? wd_q[7:0] : c2;
  // Snooped copies follow the registers' own reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c0 <= 8'h00;
      c2 <= 8'h00;
    end else begin
      c0 <= c0v;
      c2 <= c2v;
    end
  end
  // Each half of a write is caught at its own handshake.
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) st_q <= s_axi_wstrb;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
  end
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  drv_gate_a: assert property (!c2v[4] |-> pin_oe == 32'h0)
    else $error("driver on while crossbar off");
  stx_route_a: assert property (c0v[2] && c2v[4] && sig_oe[0] && !sig_out[0]
    |-> pin_oe[0] && !pin_out[0]) else $error("transmit not on pin 0");
  srx_input_a: assert property (c0v[2] && !serial0_mode0 |-> !pin_oe[1])
    else $error("receive pin driven");
  srx_odrain_a: assert property (c0v[2] && serial0_mode0 && pin_oe[1] |-> !pin_out[1])
    else $error("receive pin driven high");
  srx_sample_a: assert property ((c0v[2] && $stable(pin_in[1]))[*5]
    |-> sig_in[1] == pin_in[1]) else $error("receive level not routed");
  pullup_off_a: assert property ((pin_pullup & ((pin_oe & ~pin_out) | {32{c2v[7]}}))
    == 32'h0) else $error("pull-up on against low drive");
  cover property (c0v[2] && c2v[4] && pin_oe[0]);
  cover property (c0v[2] && serial0_mode0 && pin_oe[1]);
  cover property (c2v[7] && c2v[4]);
endmodule : pcx_checker
bind pcx_crossbar pcx_checker pcx_checker_i (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sig_out, .sig_oe, .sig_in,
  .serial0_mode0, .pin_in, .pin_out, .pin_oe, .pin_pullup);

// ==== tb/pcx_periph.sv ====
`timescale 1ns/10ps
// Peripherals and board wiring.
module pcx_periph (
  // Clock.
  input wire logic clk,
  // Commands for peripherals and board drivers.
  input wire logic [32:0] per_out,
  input wire logic [32:0] per_oe,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_oe,
  // Crossbar side.
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup,
  output logic [32:0] sig_out,
  output logic [32:0] sig_oe,
  output logic [31:0] pin_in
);
  // A floating pin has no level, so it flips.
  logic [31:0] flip = 32'h0;
  always_ff @(posedge clk) flip <= ~flip;
  // Peripherals ask; the crossbar decides whether the request reaches a pin.
  assign sig_out = per_out;
  assign sig_oe = per_oe;
  // Chip driver wins, then the board, then the weak pull-up.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
    | (~pin_oe & ~ext_oe & (pin_pullup | flip));
endmodule : pcx_periph

// ==== tb/port_crossbar_pin_assign_tb.sv ====
`timescale 1ns/10ps
// Random setups against a reference model.
module port_crossbar_pin_assign_tb;
  // Clock, reset and bus drive.
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire logic awr, wrd, bv, arr, rv;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdat, pin_in, pin_out, pin_oe, pin_pu;
  wire logic [32:0] sig_out, sig_oe, sig_in;
  // Peripheral and board commands.
  logic [32:0] per_out = 33'h0, per_oe = 33'h0;
  logic [31:0] ext_val = 32'h0, ext_oe = 32'h0;
  logic m0 = 1'b0, m1 = 1'b0, tw = 1'b0;
  logic [3:0] ws = 4'hf;
  // Stimulus and reference results.
  logic [31:0] cf, om, im, ld, st, cl, dig, e_lat, e_alloc, e_out, e_oe, e_lvl, e_pu;
  logic [32:0] e_sin;
  logic [1:0] bq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] ra[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h20, 8'h24, 8'h28,
    8'h2c, 8'h02};
  logic [31:0] rx[11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hffffffff, 32'hffffffff, 32'h0,
    32'hffffffff, 32'h0, 32'h0, 32'h0};
  pcx_crossbar pcx_crossbar_i (.clk(clk), .reset(reset), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .sig_out(sig_out), .sig_oe(sig_oe), .sig_in(sig_in), .serial0_mode0(m0),
    .serial1_mode0(m1), .spi_three_wire(tw), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pu));
  pcx_periph pcx_periph_i (.clk(clk), .per_out(per_out), .per_oe(per_oe),
    .ext_val(ext_val), .ext_oe(ext_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .sig_out(sig_out), .sig_oe(sig_oe), .pin_in(pin_in));
  initial begin
    forever #10 clk = ~clk;
  end
  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Address and data go out together; each is dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    bq = bresp;
    bry <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = pcx_pkg::RESP_OKAY);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    chk($sformatf("data at %h", a), rdat, e);
    chk($sformatf("resp at %h", a), rresp, er);
  endtask : rchk
  // Reference: each slot takes the lowest free digital pin.
  task automatic model();
    logic [32:0] en;
    logic od;
    int p;
    en = {cf[26], cf[16], cf[15], cf[22], cf[19], cf[25], cf[24], cf[14:9], cf[27], cf[8],
      cf[7], cf[6], 6'h0, {2{cf[18]}}, {2{cf[0]}}, cf[1] & ~tw, {3{cf[1]}}, {2{cf[2]}}};
    for (int i = 0; i < 6; i++) en[10 + i] = i < cf[5:3];
    dig = im | pcx_pkg::IMODE_FIXED;
    e_lat = (ld | (st & {{8{cf[31]}}, {8{cf[30]}}, {8{cf[29]}}, {8{cf[28]}}})) & ~cl;
    e_alloc = 32'h0;
    e_out = e_lat;
    e_oe = {32{cf[20]}} & (~e_lat | om);
    e_sin = '1;
    p = 0;
    for (int s = 0; s < 33; s++) begin
      while (p < 32 && en[s] && !dig[p]) p++;
      if (en[s] && p < 32) begin
        od = s == 6 || s == 7 || (s == 1 && m0) || (s == 9 && m1);
        e_alloc[p] = 1'b1;
        e_out[p] = per_out[s];
        e_oe[p] = cf[20] && per_oe[s] && (!pcx_pkg::SIG_INPUT_MASK[s] || od)
          && (!per_out[s] || (om[p] && !od));
        e_sin[s] = e_oe[p] ? per_out[s] : ext_val[p];
        p++;
      end
    end
    e_lvl = (e_oe & e_out) | (~e_oe & ext_val);
    e_pu = cf[23] ? 32'h0 : dig & ~(e_oe & ~e_out);
  endtask : model
  task automatic finish_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(30));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("pin_oe", pin_oe, 33'h0);
    chk("pin_pullup", pin_pu, 33'hffffffff);
    for (int i = 0; i < 11; i++) rchk(ra[i], rx[i], i > 8 ? 2'b10 : 2'b00);
    wr(8'h2c, 32'hffffffff);
    chk("bresp", bq, pcx_pkg::RESP_SLVERR);
    ext_oe <= 32'hffffffff;
    for (int k = 0; k < 30; k++) begin
      cf = $urandom;
      om = $urandom;
      im = $urandom;
      ld = $urandom;
      st = $urandom;
      cl = $urandom;
      ext_val <= $urandom;
      {m0, m1, tw, per_out, per_oe} <= 69'({$urandom, $urandom, $urandom});
      wr(pcx_pkg::ADDR_CFG0, {24'h0, cf[7:0]});
      wr(pcx_pkg::ADDR_CFG1, {24'h0, cf[15:8]});
      wr(pcx_pkg::ADDR_CFG3, {24'h0, cf[31:24]});
      wr(pcx_pkg::ADDR_OMODE, om);
      wr(pcx_pkg::ADDR_IMODE, im);
      wr(pcx_pkg::ADDR_DATA, ld);
      ws <= cf[31:28];
      wr(pcx_pkg::ADDR_SET, st);
      ws <= 4'hf;
      wr(pcx_pkg::ADDR_CLR, cl);
      wr(pcx_pkg::ADDR_CFG2, {24'h0, cf[23:16]});
      repeat (6) @(posedge clk);
      model();
      chk("pin_oe", pin_oe, e_oe);
      chk("pin_out", pin_out & e_oe, e_out & e_oe);
      chk("pin_pullup", pin_pu, e_pu);
      chk("sig_in", sig_in, e_sin);
      rchk(pcx_pkg::ADDR_ALLOC, e_alloc);
      rchk(pcx_pkg::ADDR_DATA, e_lvl & dig);
      rchk(pcx_pkg::ADDR_LATCH, e_lat);
      rchk(pcx_pkg::ADDR_IMODE, dig);
    end
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rchk(pcx_pkg::ADDR_OMODE, 32'h0);
    finish_test();
  end
endmodule : port_crossbar_pin_assign_tb
